// ==== src/spicfg_top.sv ====
// Purpose: SPI master chip-select configuration, interrupt enable and mask registers, and character engine.
// Assumes: Avalon-MM slave with waitrequest on a 125 MHz clock; the data-in pin is asynchronous.
// Notes:   Rules follow.
// Notes on behaviour
// - Writing one to a disable bit clears that enable; zero leaves it alone.
// - Mask register reads one for each enabled source, zero otherwise.
// - Sources sit at fixed bits zero to nine in enable, disable and mask.
// - Serial clock idles low for polarity zero and high for polarity one.
// - Phase zero changes on leading edge; phase one samples on leading edge.
// - Hold zero drops chip select right after the last transfer.
// - Hold one keeps chip select until a transfer targets another select.
// - Length code zero to eight gives eight to sixteen bits; higher codes reserved.
// - Serial clock equals master clock divided by the divisor field, or by two when the field is below two.
// - The divisor field resets to zero.
// - Lead wait is half a serial period if field zero, else field cycles.
// - Nonzero gap field inserts thirty-two times field cycles after each character.
// - Zero gap field means back-to-back characters with unbroken clock duty cycle.
`timescale 1ns/1ps
module spicfg_top (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire spicfg_pkg::spicfg_avl_req_s avl_req_i,
   output spicfg_pkg::spicfg_avl_rsp_s      avl_rsp_o,
   input  wire logic                        miso_i,
   output spicfg_pkg::spicfg_spi_s          spi_o
);
   import spicfg_pkg::*;

   // *****
   // State and helpers
   // *****
   localparam spicfg_top_s TOP_RST = '{st: ST_IDLE, waitreq: 1'b1, cs_n: 4'hF, default: '0};

   spicfg_top_s             r;
   spicfg_top_s             n;
   logic                    div_en;
   logic                    lead;
   logic                    trail;
   logic                    dly_load;
   logic [DLY_W-1:0]        dly_val;
   logic                    dly_done;
   logic [31:0]             cur_cfg;
   logic [31:0]             new_cfg;
   logic [31:0]             bem;
   logic [31:0]             rd_val;
   logic                    req;
   logic                    take;
   logic                    stall;
   logic                    sample;
   logic                    change;
   logic [15:0]             rx_new;
   logic [5:0]              last_edge;
   logic [CFG_BYTE_W-1:0]   cur_div;

   // Builds a fresh character from the holding register.
   function automatic spicfg_top_s load_char(input spicfg_top_s s, input logic [31:0] c);
      spicfg_top_s o;
      logic [3:0]  code;
      logic [4:0]  nb;
      o    = s;
      code = c[CFG_LEN_LSB +: CFG_LEN_W];
      // Reserved length codes are clamped to the longest character instead of shifting garbage.
      nb   = (code > LEN_MAX) ? BITS_MAX : (BITS_MIN + 5'(code));
      o.nbits     = nb;
      o.edge_cnt  = '0;
      o.rx        = '0;
      o.sh        = s.hold_data << (BITS_MAX - nb);
      o.hold_full = 1'b0;
      o.cur_last  = s.hold_last;
      // With capture on the leading edge the first bit must already stand before that edge.
      if (c[CFG_PHA_BIT]) begin
         o.mosi = o.sh[15];
         o.sh   = {o.sh[14:0], 1'b0};
      end
      return o;
   endfunction

   // Ends a frame or leaves the select asserted, depending on the hold setting.
   function automatic spicfg_top_s end_frame(input spicfg_top_s s, input logic [31:0] c);
      spicfg_top_s o;
      o    = s;
      o.st = ST_IDLE;
      if (!c[CFG_HOLD_BIT]) begin
         o.cs_on = 1'b0;
      end
      return o;
   endfunction

   // *****
   // Timing helpers
   // *****
   spicfg_sck_div #(
      .DIV_W (CFG_BYTE_W)
   ) u_div (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .en_i    (div_en),
      .div_i   (cur_div),
      .lead_o  (lead),
      .trail_o (trail)
   );

   spicfg_delay #(
      .W (DLY_W)
   ) u_dly (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .load_i  (dly_load),
      .value_i (dly_val),
      .done_o  (dly_done)
   );

   // *****
   // Next-state logic
   // *****
   always_comb begin
      n         = r;
      n.miso_s1 = miso_i;
      n.miso_s2 = r.miso_s1;
      div_en    = 1'b0;
      dly_load  = 1'b0;
      dly_val   = '0;
      cur_cfg   = r.cfg[r.cs_idx];
      new_cfg   = r.cfg[r.hold_cs];
      cur_div   = cur_cfg[CFG_DIV_LSB +: CFG_BYTE_W];
      bem       = {{8{avl_req_i.byteenable[3]}}, {8{avl_req_i.byteenable[2]}},
                   {8{avl_req_i.byteenable[1]}}, {8{avl_req_i.byteenable[0]}}};
      req       = avl_req_i.read || avl_req_i.write;
      take      = req && !r.waitreq;
      stall     = avl_req_i.write && (avl_req_i.address == OFS_TX) && r.hold_full;
      sample    = 1'b0;
      change    = 1'b0;
      rx_new    = r.rx;
      last_edge = 6'({r.nbits, 1'b0}) - 6'h01;

      // Read mux; unmapped and write-only offsets read as zero.
      rd_val = '0;
      if (avl_req_i.address == OFS_RX) begin
         rd_val = 32'(r.rx_data);
      end else if (avl_req_i.address == OFS_STATUS) begin
         rd_val[INT_RX_WORD_READY] = r.rx_ready;
         rd_val[INT_TX_HOLD_FREE]  = !r.hold_full;
         rd_val[INT_SHIFTER_IDLE]  = (r.st == ST_IDLE) && !r.hold_full;
      end else if (avl_req_i.address == OFS_IMASK) begin
         rd_val = 32'(r.ien);
      end else begin
         for (int i = 0; i < NUM_CS; i++) begin
            if (avl_req_i.address == OFS_CFG0 + 8'(i) * OFS_STEP) begin
               rd_val = r.cfg[i];
            end
         end
      end

      // *****
      // Avalon handshake
      // *****
      if (req && r.waitreq && !stall) begin
         n.waitreq = 1'b0;
         n.rdata   = avl_req_i.read ? rd_val : '0;
      end else begin
         n.waitreq = 1'b1;
      end

      if (take && avl_req_i.write) begin
         if (avl_req_i.address == OFS_TX) begin
            n.hold_data = avl_req_i.writedata[15:0];
            n.hold_cs   = avl_req_i.writedata[TX_CS_LSB +: 2];
            n.hold_last = avl_req_i.writedata[TX_LAST_BIT];
            n.hold_full = 1'b1;
         end else if (avl_req_i.address == OFS_IEN) begin
            n.ien = r.ien | (avl_req_i.writedata[INT_W-1:0] & bem[INT_W-1:0]);
         end else if (avl_req_i.address == OFS_IDIS) begin
            n.ien = r.ien & ~(avl_req_i.writedata[INT_W-1:0] & bem[INT_W-1:0]);
         end else begin
            for (int i = 0; i < NUM_CS; i++) begin
               if (avl_req_i.address == OFS_CFG0 + 8'(i) * OFS_STEP) begin
                  n.cfg[i] = (r.cfg[i] & ~(bem & CFG_WMASK)) | (avl_req_i.writedata & bem & CFG_WMASK);
               end
            end
         end
      end

      // Reading the received word clears its flag; a word landing in the same cycle wins below.
      if (take && avl_req_i.read && (avl_req_i.address == OFS_RX)) begin
         n.rx_ready = 1'b0;
      end

      // *****
      // Character engine
      // *****
      case (r.st)
         ST_IDLE: begin
            n.sclk = cur_cfg[CFG_POL_BIT];
            if (r.hold_full) begin
               if (r.cs_on && (r.cs_idx == r.hold_cs)) begin
                  n    = load_char(n, new_cfg);
                  n.st = ST_SHIFT;
               end else begin
                  // A held select is released only when another select is addressed.
                  n        = load_char(n, new_cfg);
                  n.cs_on  = 1'b1;
                  n.cs_idx = r.hold_cs;
                  n.sclk   = new_cfg[CFG_POL_BIT];
                  if (new_cfg[CFG_PRE_LSB +: CFG_BYTE_W] == '0) begin
                     dly_val = DLY_W'((new_cfg[CFG_DIV_LSB +: CFG_BYTE_W] < 8'h02) ? 8'h01
                                      : (new_cfg[CFG_DIV_LSB +: CFG_BYTE_W] >> 1));
                  end else begin
                     dly_val = DLY_W'(new_cfg[CFG_PRE_LSB +: CFG_BYTE_W]);
                  end
                  // The clock edge lands a cycle after the wait, so the wait stops one short.
                  dly_val  = dly_val - DLY_W'(1);
                  dly_load = (dly_val != '0);
                  n.st     = (dly_val != '0) ? ST_LEAD : ST_SHIFT;
               end
            end
         end
         ST_LEAD: begin
            if (dly_done) begin
               n.st = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            div_en = 1'b1;
            if (lead || trail) begin
               n.sclk   = !r.sclk;
               sample   = cur_cfg[CFG_PHA_BIT] ? lead : trail;
               change   = cur_cfg[CFG_PHA_BIT] ? (trail && ({1'b0, r.edge_cnt} != last_edge)) : lead;
               n.edge_cnt = r.edge_cnt + 5'h01;
               if (change) begin
                  n.mosi = r.sh[15];
                  n.sh   = {r.sh[14:0], 1'b0};
               end
               if (sample) begin
                  rx_new = {r.rx[14:0], r.miso_s2};
                  n.rx   = rx_new;
               end
               if ({1'b0, r.edge_cnt} == last_edge) begin
                  n.rx_data  = rx_new;
                  n.rx_ready = 1'b1;
                  // A last character idles a cycle so the select never moves with the clock.
                  if ((cur_cfg[CFG_GAP_LSB +: CFG_BYTE_W] != '0) || r.cur_last) begin
                     dly_load = 1'b1;
                     dly_val  = (cur_cfg[CFG_GAP_LSB +: CFG_BYTE_W] != '0)
                                ? {cur_cfg[CFG_GAP_LSB +: CFG_BYTE_W], GAP_SHIFT'(0)} : DLY_W'(1);
                     n.st     = ST_GAP;
                  end else if (r.hold_full && (r.hold_cs == r.cs_idx)) begin
                     // Staying in this state keeps the divider running, so the duty cycle is unbroken.
                     n    = load_char(n, cur_cfg);
                     n.st = ST_SHIFT;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end
            end
         end
         ST_GAP: begin
            // The gap also runs before any select release.
            if (dly_done) begin
               if (r.cur_last) begin
                  n = end_frame(n, cur_cfg);
               end else begin
                  n.st = ST_IDLE;
               end
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      n.cs_n = n.cs_on ? ~(4'h1 << n.cs_idx) : 4'hF;
   end

   // *****
   // State register
   // *****
   // The divisor resets to zero along with the rest of each configuration word.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= TOP_RST;
      end else begin
         r <= n;
      end
   end

   assign avl_rsp_o = '{readdata: r.rdata, waitrequest: r.waitreq};
   assign spi_o     = '{sclk: r.sclk, mosi: r.mosi, cs_n: r.cs_n};

endmodule // spicfg_top

// ==== src/spicfg_pkg.sv ====
// Purpose: Shared constants, types and carriers of the SPI chip-select timing and configuration block.
// Assumes: 32-bit Avalon-MM register bus with byte addresses; four chip selects; 16-bit character data.
// Notes:   Every offset and field position used by the logic is named here; the reset state of spicfg_top is set in that module.
package spicfg_pkg;

   // *****
   // Register map (byte offsets)
   // *****
   localparam logic [7:0]  OFS_TX      = 8'h00;
   localparam logic [7:0]  OFS_RX      = 8'h04;
   localparam logic [7:0]  OFS_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_IEN     = 8'h0C;
   localparam logic [7:0]  OFS_IDIS    = 8'h10;
   localparam logic [7:0]  OFS_IMASK   = 8'h14;
   localparam logic [7:0]  OFS_CFG0    = 8'h20;
   localparam logic [7:0]  OFS_STEP    = 8'h04;
   localparam int unsigned NUM_CS      = 4;

   // *****
   // Interrupt source bit positions
   // *****
   localparam int unsigned INT_RX_WORD_READY  = 0;
   localparam int unsigned INT_TX_HOLD_FREE   = 1;
   localparam int unsigned INT_BUS_CONFLICT   = 2;
   localparam int unsigned INT_RX_OVERRUN     = 3;
   localparam int unsigned INT_RX_BLOCK_END   = 4;
   localparam int unsigned INT_TX_BLOCK_END   = 5;
   localparam int unsigned INT_RX_BLOCK_FULL  = 6;
   localparam int unsigned INT_TX_BLOCK_EMPTY = 7;
   localparam int unsigned INT_SEL_RISE       = 8;
   localparam int unsigned INT_SHIFTER_IDLE   = 9;
   localparam int unsigned INT_W              = 10;

   // *****
   // Configuration and transmit word fields
   // *****
   localparam int unsigned CFG_POL_BIT  = 0;
   localparam int unsigned CFG_PHA_BIT  = 1;
   localparam int unsigned CFG_HOLD_BIT = 3;
   localparam int unsigned CFG_LEN_LSB  = 4;
   localparam int unsigned CFG_LEN_W    = 4;
   localparam int unsigned CFG_DIV_LSB  = 8;
   localparam int unsigned CFG_PRE_LSB  = 16;
   localparam int unsigned CFG_GAP_LSB  = 24;
   localparam int unsigned CFG_BYTE_W   = 8;
   localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK    = 32'hFFFF_FFFB;
   localparam logic [3:0]  LEN_MAX      = 4'h8;
   localparam logic [4:0]  BITS_MIN     = 5'h08;
   localparam logic [4:0]  BITS_MAX     = 5'h10;
   localparam int unsigned GAP_UNIT     = 32;
   localparam int unsigned GAP_SHIFT    = $clog2(GAP_UNIT);
   localparam int unsigned DLY_W        = CFG_BYTE_W + GAP_SHIFT;
   localparam int unsigned TX_CS_LSB    = 16;
   localparam int unsigned TX_LAST_BIT  = 24;

   // *****
   // Types
   // *****
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_LEAD  = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_GAP   = 4'b1000
   } spicfg_state_e;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } spicfg_avl_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } spicfg_avl_rsp_s;

   typedef struct packed {
      logic        sclk;
      logic        mosi;
      logic [3:0]  cs_n;
   } spicfg_spi_s;

   typedef struct packed {
      spicfg_state_e           st;
      logic [NUM_CS-1:0][31:0] cfg;
      logic [INT_W-1:0]        ien;
      logic [15:0]             hold_data;
      logic [1:0]              hold_cs;
      logic                    hold_last;
      logic                    hold_full;
      logic                    cs_on;
      logic [1:0]              cs_idx;
      logic                    cur_last;
      logic [4:0]              nbits;
      logic [4:0]              edge_cnt;
      logic [15:0]             sh;
      logic [15:0]             rx;
      logic [15:0]             rx_data;
      logic                    rx_ready;
      logic                    sclk;
      logic                    mosi;
      logic [3:0]              cs_n;
      logic                    miso_s1;
      logic                    miso_s2;
      logic                    waitreq;
      logic [31:0]             rdata;
   } spicfg_top_s;

endpackage

// ==== src/spicfg_sck_div.sv ====
// Purpose: Modulus counter that marks the leading and trailing serial clock edges.
// Assumes: Divisor sampled every cycle; a divisor below two runs at half the master clock.
// Notes:   Edges are one-cycle enable pulses; the counter restarts whenever enable drops.
`timescale 1ns/1ps
module spicfg_sck_div #(
   parameter int unsigned DIV_W = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             en_i,
   input  wire logic [DIV_W-1:0] div_i,
   output logic                  lead_o,
   output logic                  trail_o
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
   } spicfg_div_s;

   spicfg_div_s      r;
   spicfg_div_s      n;
   logic [DIV_W-1:0] period;
   logic [DIV_W-1:0] half;

   // A one-cycle period cannot be drawn by a registered pin, so it is widened to two.
   always_comb begin
      period  = (div_i < DIV_W'(2)) ? DIV_W'(2) : div_i;
      half    = period >> 1;
      n       = r;
      lead_o  = en_i && (r.cnt == '0);
      trail_o = en_i && (r.cnt == half);
      if (!en_i) begin
         n.cnt = '0;
      end else if (r.cnt == period - DIV_W'(1)) begin
         n.cnt = '0;
      end else begin
         n.cnt = r.cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // spicfg_sck_div

// ==== src/spicfg_delay.sv ====
// Purpose: Loadable down counter that flags the end of a programmed wait in master clock cycles.
// Assumes: A load value of at least one.
// Notes:   Done is high in the last cycle of the wait, so the caller moves on exactly value cycles after load.
`timescale 1ns/1ps
module spicfg_delay #(
   parameter int unsigned W = 13
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] value_i,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } spicfg_dly_s;

   spicfg_dly_s r;
   spicfg_dly_s n;

   always_comb begin
      n      = r;
      done_o = (r.cnt == W'(1));
      if (load_i) begin
         n.cnt = value_i;
      end else if (r.cnt != '0) begin
         n.cnt = r.cnt - W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // spicfg_delay

// ==== testbench/spicfg_properties.sv ====
// Purpose: Port-level assertions for spicfg_top.
// Assumes: Bound into every spicfg_top instance.
// Notes:   Shadow registers follow acknowledged writes.
`timescale 1ns/1ps
module spicfg_properties (
   input wire logic                    clk_i,
   input wire logic                    rst_b_i,
   input wire spicfg_pkg::spicfg_avl_req_s avl_req_i,
   input wire spicfg_pkg::spicfg_avl_rsp_s avl_rsp_o,
   input wire spicfg_pkg::spicfg_spi_s     spi_o
);
   import spicfg_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // *****
   // Shadow state
   // *****
   logic [INT_W-1:0] ien_sh;
   logic [3:0][31:0] cfg_sh;
   logic             hold_q;
   logic [31:0]      bm;
   logic             wack;
   logic             rack;
   assign bm = {{8{avl_req_i.byteenable[3]}}, {8{avl_req_i.byteenable[2]}},
                {8{avl_req_i.byteenable[1]}}, {8{avl_req_i.byteenable[0]}}};
   assign wack = avl_req_i.write && !avl_rsp_o.waitrequest;
   assign rack = avl_req_i.read && !avl_rsp_o.waitrequest;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ien_sh <= '0;
         cfg_sh <= '0;
         hold_q <= 1'b0;
      end else begin
         hold_q <= |(~spi_o.cs_n & {cfg_sh[3][CFG_HOLD_BIT], cfg_sh[2][CFG_HOLD_BIT],
                                     cfg_sh[1][CFG_HOLD_BIT], cfg_sh[0][CFG_HOLD_BIT]});
         if (wack && avl_req_i.address == OFS_IEN)
            ien_sh <= ien_sh | (avl_req_i.writedata[INT_W-1:0] & bm[INT_W-1:0]);
         if (wack && avl_req_i.address == OFS_IDIS)
            ien_sh <= ien_sh & ~(avl_req_i.writedata[INT_W-1:0] & bm[INT_W-1:0]);
         if (wack && (avl_req_i.address & 8'hF3) == OFS_CFG0)
            cfg_sh[avl_req_i.address[3:2]] <= (cfg_sh[avl_req_i.address[3:2]] & ~(bm & CFG_WMASK))
                                            | (avl_req_i.writedata & bm & CFG_WMASK);
      end
   end
   // *****
   // Assertions
   // *****
   a_ack_one_cycle: assert property (
      !avl_rsp_o.waitrequest |=> avl_rsp_o.waitrequest) else $error("waitrequest low too long");
   a_ack_after_req: assert property (
      $fell(avl_rsp_o.waitrequest) |-> $past(avl_req_i.read || avl_req_i.write)) else $error("answer without request");
   a_read_answer: assert property (
      avl_req_i.read && avl_rsp_o.waitrequest |=> !avl_rsp_o.waitrequest) else $error("read not answered");
   a_mask_readback: assert property (
      rack && avl_req_i.address == OFS_IMASK |-> avl_rsp_o.readdata == {{(32-INT_W){1'b0}}, ien_sh})
      else $error("mask read wrong");
   a_disable_reads_zero: assert property (
      rack && (avl_req_i.address == OFS_IDIS || avl_req_i.address == OFS_IEN) |-> avl_rsp_o.readdata == '0)
      else $error("write-only read nonzero");
   a_cfg_readback: assert property (
      rack && (avl_req_i.address & 8'hF3) == OFS_CFG0 |-> avl_rsp_o.readdata == cfg_sh[avl_req_i.address[3:2]])
      else $error("config read wrong");
   a_select_onehot: assert property (
      $onehot0(~spi_o.cs_n)) else $error("more than one select active");
   a_hold_keeps_cs: assert property (
      $rose(&spi_o.cs_n) |-> !hold_q) else $error("held select released");
endmodule // spicfg_properties

bind spicfg_top spicfg_properties u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .avl_req_i(avl_req_i),
   .avl_rsp_o(avl_rsp_o), .spi_o(spi_o));

// ==== testbench/spicfg_slave_model.sv ====
// Purpose: Behavioural serial slave, most significant bit first.
// Assumes: Mode inputs match the select's configuration.
// Notes:   When deselected the data line shows the inverse of its last value.
`timescale 1ns/1ps
module spicfg_slave_model (
   input  wire logic        sclk_i,
   input  wire logic        mosi_i,
   input  wire logic        sel_b_i,
   input  wire logic        pol_i,
   input  wire logic        pha_i,
   input  wire logic [15:0] patt_i,
   output logic             miso_o,
   output logic [15:0]      rx_o
);
   logic [15:0] sh;
   initial begin
      miso_o = 1'b0;
      rx_o = '0;
      sh = '0;
   end
   always @(negedge sel_b_i) begin
      sh = patt_i;
      if (pha_i) begin
         miso_o = sh[15];
         sh = sh << 1;
      end
   end
   always @(posedge sel_b_i) miso_o = ~miso_o;
   // A leading edge leaves the idle level; phase picks capture or change on it.
   always @(sclk_i) begin
      if (!sel_b_i) begin
         if ((sclk_i != pol_i) == pha_i) rx_o = {rx_o[14:0], mosi_i};
         else begin
            miso_o = sh[15];
            sh = sh << 1;
         end
      end
   end
endmodule // spicfg_slave_model

// ==== testbench/test_spi_chip_select_timing_config.sv ====
// Purpose: Self-checking bench for spicfg_top with four slave models.
// Assumes: Even divisors.
// Notes:   The monitor times lead wait, longest quiet gap and edges per frame.
`timescale 1ns/1ps
module test_spi_chip_select_timing_config;
   import spicfg_pkg::*;
   logic             clk_i = 1'b0;
   logic             rst_b_i = 1'b0;
   spicfg_avl_req_s  avl_req = '0;
   spicfg_avl_rsp_s  avl_rsp;
   spicfg_spi_s      spi;
   logic             miso;
   logic [3:0]       sm;
   logic [3:0]       spol = '0;
   logic [3:0]       spha = '0;
   logic [3:0][15:0] spat = {4{16'hD2B7}};
   logic [3:0][15:0] srx;
   logic             sk_q = 1'b0;
   logic             cs_q = 1'b1;
   logic             first = 1'b0;
   int               errors = 0, compares = 0, ic = 0, lead = 0, qmax = 0, ec = 0;
   always #4 clk_i = ~clk_i;
   spicfg_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .avl_req_i(avl_req), .avl_rsp_o(avl_rsp),
                     .miso_i(miso), .spi_o(spi));
   for (genvar k = 0; k < 4; k++) begin : g_sl
      spicfg_slave_model sl_u (.sclk_i(spi.sclk), .mosi_i(spi.mosi), .sel_b_i(spi.cs_n[k]), .pol_i(spol[k]),
                               .pha_i(spha[k]), .patt_i(spat[k]), .miso_o(sm[k]), .rx_o(srx[k]));
   end
   always_comb begin
      miso = sm[0];
      for (int k = 0; k < 4; k++) if (!spi.cs_n[k]) miso = sm[k];
   end
   // *****
   // Frame monitor
   // *****
   always @(negedge clk_i) begin
      sk_q <= spi.sclk;
      cs_q <= &spi.cs_n;
      if (&spi.cs_n) ic <= 0;
      else if (cs_q) begin
         ic <= 1;
         first <= 1'b1;
         qmax <= 0;
         ec <= 0;
      end else if (spi.sclk !== sk_q) begin
         ic <= 1;
         ec <= ec + 1;
         first <= 1'b0;
         if (first) lead <= ic;
         else if (ic > qmax) qmax <= ic;
      end else ic <= ic + 1;
   end
   // *****
   // Tasks
   // *****
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      avl_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (avl_rsp.waitrequest !== 1'b0 && n < 3000);
      @(posedge clk_i);
      q = avl_rsp.readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
      if (n >= 3000) begin errors++; stop_test(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(nm, q, e);
   endtask
   task automatic wait_idle();
      logic [31:0] q;
      int n = 0;
      do begin
         bus(1'b0, OFS_STATUS, 32'h0, q);
         n++;
      end while (q[INT_SHIFTER_IDLE] !== 1'b1 && n < 500);
      if (n >= 500) begin errors++; stop_test(); end
      repeat (4) @(posedge clk_i);
   endtask
   function automatic logic [31:0] cfgw(input logic [7:0] g, p, dv, input logic [3:0] ln, input logic h, ph, pl);
      return {g, p, dv, ln, h, 1'b0, ph, pl};
   endfunction
   task automatic t_regs();
      logic [9:0] en;
      for (int k = 0; k < 4; k++) rdc("cfg reset", 8'(OFS_CFG0 + OFS_STEP * k), 32'h0);
      rdc("mask reset", OFS_IMASK, 32'h0);
      wr(OFS_IEN, 32'hFFFF_FFFF);
      en = 10'h3FF;
      rdc("mask all", OFS_IMASK, {22'h0, en});
      for (int k = 0; k < INT_W; k++) begin
         wr(OFS_IDIS, 32'h1 << k);
         en[k] = 1'b0;
         rdc("mask bit", OFS_IMASK, {22'h0, en});
      end
      wr(OFS_IEN, 32'h0000_02A5);
      wr(OFS_IDIS, 32'h0);
      rdc("mask keep", OFS_IMASK, 32'h0000_02A5);
      rdc("disable read", OFS_IDIS, 32'h0);
      rdc("unmapped", 8'h3C, 32'h0);
      wr(OFS_CFG0 + OFS_STEP, 32'hFFFF_FFFF);
      rdc("cfg fields", OFS_CFG0 + OFS_STEP, CFG_WMASK);
      $display("regs test done");
   endtask
   task automatic t_modes();
      logic [3:0]  ln [4] = '{4'h0, 4'h1, 4'h7, 4'h8};
      logic [15:0] d, msk;
      int n, p;
      for (int m = 0; m < 4; m++) begin
         n = 8 + ln[m];
         p = m[0] ? 6 : 0;
         msk = 16'hFFFF >> (16 - n);
         d = 16'h9C5A & msk;
         wr(OFS_CFG0, cfgw(8'h0, 8'(p), 8'h08, ln[m], 1'b0, m[0], m[1]));
         spol[0] <= m[1];
         spha[0] <= m[0];
         wr(OFS_TX, {7'h00, 1'b1, 8'h00, d});
         wait_idle();
         check("idle level", spi.sclk, m[1]);
         check("select off", spi.cs_n, 4'hF);
         check("edge count", ec, 2 * n);
         check("lead wait", lead, p ? p : 4);
         check("half period", qmax, 4);
         check("slave rx", srx[0] & msk, d);
         rdc("rx word", OFS_RX, 16'hD2B7 >> (16 - n));
      end
      $display("modes test done");
   endtask
   task automatic t_gap();
      for (int g = 0; g < 2; g++) begin
         wr(OFS_CFG0, cfgw(8'(g), 8'h0, 8'h06, 4'h0, 1'b0, 1'b0, 1'b0));
         spol[0] <= 1'b0;
         spha[0] <= 1'b0;
         wr(OFS_TX, 32'h0000_00C3);
         wr(OFS_TX, 32'h0100_005A);
         wait_idle();
         check("char pair", srx[0], 16'hC35A);
         check("pair edges", ec, 32);
         if (g == 0) check("no gap", qmax, 3);
         else check("gap span", qmax >= 32 && qmax <= 40, 1);
      end
      $display("gap test done");
   endtask
   task automatic t_hold();
      wr(OFS_CFG0, cfgw(8'h0, 8'h0, 8'h08, 4'h0, 1'b1, 1'b0, 1'b0));
      wr(OFS_CFG0 + OFS_STEP, cfgw(8'h0, 8'h0, 8'h08, 4'h0, 1'b0, 1'b0, 1'b0));
      spol <= '0;
      spha <= '0;
      wr(OFS_TX, 32'h0100_0081);
      wait_idle();
      check("held select", spi.cs_n, 4'hE);
      wr(OFS_TX, 32'h0101_007E);
      wait_idle();
      check("released", spi.cs_n, 4'hF);
      check("second rx", srx[1][7:0], 8'h7E);
      $display("hold test done");
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_modes();
      t_gap();
      t_hold();
      stop_test();
   end
endmodule // test_spi_chip_select_timing_config
